//--- mac_far_model.sv
// Far-end model: transmitter frame events and the carrier pin.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
module mac_far_model (
  // Clock
  input wire logic ref_clk,
  // Towards the status bank
  output logic carrier_sense_pin,
  output logic tx_frame_start,
  output logic tx_frame_ok,
  output logic tx_collision,
  output logic tx_last_packet
);
  initial begin
    carrier_sense_pin = 1'b0;
    tx_frame_start = 1'b0;
    tx_frame_ok = 1'b0;
    tx_collision = 1'b0;
    tx_last_packet = 1'b1;
  end
  // One-cycle event: 0 start, 1 sent, 2 collision
  task automatic ev(input int k);
    @(posedge ref_clk);
    tx_frame_start <= (k == 0);
    tx_frame_ok <= (k == 1);
    tx_collision <= (k == 2);
    @(posedge ref_clk);
    tx_frame_start <= 1'b0;
    tx_frame_ok <= 1'b0;
    tx_collision <= 1'b0;
  endtask
  task automatic carrier(input logic v);
    @(posedge ref_clk);
    carrier_sense_pin <= v;
  endtask
endmodule

//--- mac_status_regs.sv
// Transmit and receive status, interrupt enables and address tables.
// Assumes same-clock event pulses from the MAC and a plain register port.
//
// How it works
// - Done flag when active bank finished
// - Only tx bits 7,2,1 raise interrupts
// - Writing one clears tx flags 7,2,1, zero ignored
// - Clearing flag also drops its request
// - Bit 6 mirrors live carrier sense
// - Self-reception flag, cleared at transmission start
// - Carrier lost during send, cleared at start
// - Collision flag, retry up to fifteen
// - Excess flag after sixteenth failed attempt
// - Reserved bits read zero, written zero
// - Latched flags reset to zero
// - Each rx flag gated by enable
// - Packet flag on every stored packet
// - Remote flag for type 0900
// - Rx bits 1-3 report packet errors
// - Accept controls store errors in header
// - Both accepts off discards errored packets
// - Header length and status byte layout
// - Rx flags write-one-to-clear, set internally
// - Tx enable bit 7 gates done flag
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
module mac_status_regs #(
  parameter int SELF_RX_CYCLES = macst_pkg::SELF_RX_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [macst_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // Pin
  input wire logic carrier_sense_pin,
  // Transmitter events
  input wire logic tx_frame_start,
  input wire logic tx_frame_ok,
  input wire logic tx_collision,
  input wire logic tx_last_packet,
  input wire logic refl_tick,
  input wire logic [7:0] tx_hdr_lo,
  input wire logic [7:0] tx_hdr_hi,
  input wire logic tx_hdr_load,
  // Receiver events
  input wire logic rx_frame_end,
  input wire logic rx_crc_err,
  input wire logic rx_align_err,
  input wire logic [macst_pkg::LEN_W-1:0] rx_length,
  input wire logic [15:0] rx_type,
  input wire logic rx_buffer_full,
  input wire logic bus_read_err,
  input wire logic dma_end,
  // Transmitter controls
  output logic tx_go,
  output logic [6:0] tx_packet_count,
  output logic tx_retry,
  output logic tx_skip,
  output logic tx_busy,
  output logic [macst_pkg::LEN_W-1:0] tx_frame_length,
  // Receive buffer controls
  output logic rx_store,
  output logic rx_discard,
  output logic [7:0] rx_hdr_status,
  output logic [7:0] rx_hdr_reserved,
  output logic [7:0] rx_hdr_len_lo,
  output logic [7:0] rx_hdr_len_hi,
  // Address filters
  output logic [47:0] station_address,
  output logic [63:0] multicast_table,
  // Interrupt request
  output logic irq
);
  // ==========================================
  // Storage and wires
  macst_pkg::tx_state_t tx_state_reg;
  logic [7:0] tx_irq_enable_reg;
  logic [7:0] rx_irq_enable_reg;
  logic [7:0] receive_mode_reg;
  logic [7:0] tx_start_shadow_reg;
  logic [3:0] coll_count_reg;
  logic [macst_pkg::REFL_W-1:0] refl_count_reg;
  logic refl_stop_reg;
  logic [macst_pkg::WIN_W-1:0] self_rx_win_reg;
  logic frame_active_reg;
  logic carrier_prev_reg;
  logic overflow_pending_reg;
  logic [7:0] node_reg [macst_pkg::NODE_BYTES];
  logic [7:0] hash_reg [macst_pkg::HASH_BYTES];
  logic carrier_sense_image;
  logic [7:0] tx_flags;
  logic [7:0] rx_flags;
  logic [7:0] tx_set;
  logic [7:0] tx_clr;
  logic [7:0] rx_set;
  logic [7:0] rx_clr;
  logic [7:0] transmit_status_reg;
  logic [7:0] receive_status_reg;
  logic [7:0] rd_next;
  logic wr_tx_status;
  logic wr_rx_status;
  logic go_write;
  logic excess;
  logic packet_end;
  logic rx_short;
  logic rx_errored;
  logic rx_accept;
  logic accept_errored_packets;
  logic accept_runt_packets;

  pin_sync carrier_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin(carrier_sense_pin),
    .level(carrier_sense_image)
  );

  // ==========================================
  // Transmit sequencing
  assign go_write = wr_en && addr == macst_pkg::TX_START_ADDR && wr_data[macst_pkg::TX_GO_BIT];
  assign excess = tx_collision && frame_active_reg && coll_count_reg == macst_pkg::MAX_RETRY;
  assign packet_end = tx_frame_ok || excess;
  assign tx_busy = tx_state_reg == macst_pkg::TX_SEND;
  assign tx_go = go_write && tx_state_reg == macst_pkg::TX_IDLE;
  assign tx_retry = tx_collision && frame_active_reg && !excess;
  assign tx_skip = excess;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_state_reg <= macst_pkg::TX_IDLE;
    end else begin
      unique case (tx_state_reg)
        macst_pkg::TX_IDLE: begin
          if (tx_go) begin
            tx_state_reg <= macst_pkg::TX_SEND;
          end
        end
        macst_pkg::TX_SEND: begin
          if (packet_end && tx_last_packet) begin
            tx_state_reg <= macst_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_state_reg <= macst_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Consecutive collisions on the current packet
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      coll_count_reg <= 4'h0;
    end else if (tx_frame_ok || excess) begin
      coll_count_reg <= 4'h0;
    end else if (tx_retry) begin
      coll_count_reg <= coll_count_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frame_active_reg <= 1'b0;
      carrier_prev_reg <= 1'b0;
    end else begin
      carrier_prev_reg <= carrier_sense_image;
      if (tx_frame_start) begin
        frame_active_reg <= 1'b1;
      end else if (tx_frame_ok || tx_collision) begin
        frame_active_reg <= 1'b0;
      end
    end
  end

  // Reflectometry count: runs from frame start until a collision or the good end of the frame
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      refl_count_reg <= '0;
      refl_stop_reg <= 1'b0;
    end else if (tx_frame_start) begin
      refl_count_reg <= '0;
      refl_stop_reg <= 1'b0;
    end else begin
      if (tx_collision) begin
        refl_stop_reg <= 1'b1;
      end
      if (refl_tick && frame_active_reg && !refl_stop_reg && !(&refl_count_reg)) begin
        refl_count_reg <= refl_count_reg + 1'b1;
      end
    end
  end

  // Window after a good frame in which our own packet may come back
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      self_rx_win_reg <= '0;
    end else if (tx_frame_ok) begin
      self_rx_win_reg <= macst_pkg::WIN_W'(SELF_RX_CYCLES);
    end else if (self_rx_win_reg != '0) begin
      self_rx_win_reg <= self_rx_win_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_frame_length <= '0;
    end else if (tx_hdr_load) begin
      tx_frame_length <= {tx_hdr_hi[2:0], tx_hdr_lo};
    end
  end

  // ==========================================
  // Receive acceptance
  assign accept_errored_packets = receive_mode_reg[macst_pkg::RXM_ACCEPT_ERR];
  assign accept_runt_packets = receive_mode_reg[macst_pkg::RXM_ACCEPT_RUNT];
  assign rx_short = rx_length < macst_pkg::MIN_FRAME_LEN;
  assign rx_errored = rx_crc_err || rx_align_err || rx_short;
  assign rx_accept = rx_frame_end && !rx_buffer_full && (!rx_errored || accept_errored_packets
    || accept_runt_packets);
  assign rx_store = rx_accept;
  assign rx_discard = rx_frame_end && !rx_accept;

  // Header bytes for the buffer controller
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_hdr_status <= 8'h00;
      rx_hdr_reserved <= 8'h00;
      rx_hdr_len_lo <= 8'h00;
      rx_hdr_len_hi <= 8'h00;
      overflow_pending_reg <= 1'b0;
    end else begin
      if (rx_frame_end && rx_buffer_full) begin
        overflow_pending_reg <= 1'b1;
      end
      if (rx_accept) begin
        overflow_pending_reg <= 1'b0;
        rx_hdr_status <= 8'h00;
        rx_hdr_status[macst_pkg::HDR_GOOD] <= !rx_errored;
        rx_hdr_status[macst_pkg::RXS_REMOTE] <= rx_type == macst_pkg::REMOTE_TYPE;
        rx_hdr_status[macst_pkg::RXS_SHORT] <= rx_short;
        rx_hdr_status[macst_pkg::RXS_ALIGN] <= rx_align_err;
        rx_hdr_status[macst_pkg::RXS_CRC] <= rx_crc_err;
        rx_hdr_status[macst_pkg::RXS_OVF] <= overflow_pending_reg;
        rx_hdr_len_lo <= rx_length[7:0];
        rx_hdr_len_hi <= {5'h00, rx_length[10:8]};
      end
    end
  end

  // ==========================================
  // Status flags
  assign wr_tx_status = wr_en && addr == macst_pkg::TX_STATUS_ADDR;
  assign wr_rx_status = wr_en && addr == macst_pkg::RX_STATUS_ADDR;

  always_comb begin
    tx_set = 8'h00;
    tx_clr = 8'h00;
    tx_set[macst_pkg::TXS_DONE] = tx_busy && packet_end && tx_last_packet;
    tx_set[macst_pkg::TXS_SELF_RX] = rx_accept && !rx_errored && self_rx_win_reg != '0;
    tx_set[macst_pkg::TXS_CARRIER_LOST_FLAG] = frame_active_reg && carrier_prev_reg && !carrier_sense_image;
    tx_set[macst_pkg::TXS_COLL] = tx_collision && frame_active_reg;
    tx_set[macst_pkg::TXS_EXCESS] = excess;
    tx_clr = wr_tx_status ? (wr_data & macst_pkg::TX_IRQ_MASK) : 8'h00;
    tx_clr[macst_pkg::TXS_SELF_RX] = tx_frame_start;
    tx_clr[macst_pkg::TXS_CARRIER_LOST_FLAG] = tx_frame_start;
  end

  always_comb begin
    rx_set = 8'h00;
    rx_set[macst_pkg::RXS_PKT] = rx_accept;
    rx_set[macst_pkg::RXS_BUS_RD] = bus_read_err;
    rx_set[macst_pkg::RXS_DMA_EOP] = dma_end;
    rx_set[macst_pkg::RXS_REMOTE] = rx_accept && rx_type == macst_pkg::REMOTE_TYPE;
    rx_set[macst_pkg::RXS_SHORT] = rx_accept && rx_short;
    rx_set[macst_pkg::RXS_ALIGN] = rx_accept && rx_align_err;
    rx_set[macst_pkg::RXS_CRC] = rx_accept && rx_crc_err;
    rx_set[macst_pkg::RXS_OVF] = rx_frame_end && rx_buffer_full;
    rx_clr = wr_rx_status ? wr_data : 8'h00;
  end

  // Unused tx positions are never set, so they hold at zero
  for (genvar i = 0; i < 8; i++) begin : g_flags
    status_flag tx_flag (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .set(tx_set[i]),
      .clear(tx_clr[i]),
      .flag(tx_flags[i])
    );
    status_flag rx_flag (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .set(rx_set[i]),
      .clear(rx_clr[i]),
      .flag(rx_flags[i])
    );
  end

  always_comb begin
    transmit_status_reg = tx_flags;
    transmit_status_reg[macst_pkg::TXS_CARRIER] = carrier_sense_image;
    transmit_status_reg[3] = 1'b0;
    transmit_status_reg[0] = 1'b0;
    receive_status_reg = rx_flags;
  end

  // Request follows the stored flags, so a clear drops it next cycle
  assign irq = |(tx_flags & tx_irq_enable_reg & macst_pkg::TX_IRQ_MASK)
    || |(rx_flags & rx_irq_enable_reg);

  // ==========================================
  // Register writes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_irq_enable_reg <= 8'h00;
      rx_irq_enable_reg <= 8'h00;
      receive_mode_reg <= 8'h00;
      tx_start_shadow_reg <= 8'h00;
    end else if (wr_en) begin
      unique case (addr)
        macst_pkg::TX_IRQ_EN_ADDR: tx_irq_enable_reg <= wr_data & macst_pkg::TX_IRQ_MASK;
        macst_pkg::RX_IRQ_EN_ADDR: rx_irq_enable_reg <= wr_data;
        macst_pkg::RX_MODE_ADDR: begin
          receive_mode_reg <= 8'h00;
          receive_mode_reg[macst_pkg::RXM_ACCEPT_ERR] <= wr_data[macst_pkg::RXM_ACCEPT_ERR];
          receive_mode_reg[macst_pkg::RXM_ACCEPT_RUNT] <= wr_data[macst_pkg::RXM_ACCEPT_RUNT];
        end
        macst_pkg::TX_START_ADDR: tx_start_shadow_reg <= {1'b0, wr_data[6:0]};
        default: begin
        end
      endcase
    end
  end

  assign tx_packet_count = tx_start_shadow_reg[6:0];

  // Address tables have no reset: software loads them before use
  for (genvar n = 0; n < macst_pkg::NODE_BYTES; n++) begin : g_node
    always_ff @(posedge ref_clk) begin
      if (wr_en && addr == macst_pkg::NODE_ADDR_BASE + 5'(n)) begin
        node_reg[n] <= wr_data;
      end
    end
    assign station_address[8*n +: 8] = node_reg[n];
  end

  for (genvar h = 0; h < macst_pkg::HASH_BYTES; h++) begin : g_hash
    always_ff @(posedge ref_clk) begin
      if (wr_en && addr == macst_pkg::HASH_BASE + 5'(h)) begin
        hash_reg[h] <= wr_data;
      end
    end
    assign multicast_table[8*h +: 8] = hash_reg[h];
  end

  // ==========================================
  // Read port: data stand only in the cycle after the strobe
  always_comb begin
    rd_next = 8'h00;
    if (addr >= macst_pkg::NODE_ADDR_BASE && addr < macst_pkg::REFL_LOW_ADDR) begin
      rd_next = node_reg[3'(addr - macst_pkg::NODE_ADDR_BASE)];
    end else if (addr >= macst_pkg::HASH_BASE && addr < macst_pkg::TX_START_ADDR) begin
      rd_next = hash_reg[3'(addr - macst_pkg::HASH_BASE)];
    end else begin
      unique case (addr)
        macst_pkg::TX_STATUS_ADDR: rd_next = transmit_status_reg;
        macst_pkg::RX_STATUS_ADDR: rd_next = receive_status_reg;
        macst_pkg::TX_IRQ_EN_ADDR: rd_next = tx_irq_enable_reg;
        macst_pkg::RX_IRQ_EN_ADDR: rd_next = rx_irq_enable_reg;
        macst_pkg::TX_MODE_ADDR: rd_next = {coll_count_reg, 4'h0};
        macst_pkg::RX_MODE_ADDR: rd_next = receive_mode_reg;
        macst_pkg::REFL_LOW_ADDR: rd_next = refl_count_reg[7:0];
        macst_pkg::REFL_HIGH_ADDR: rd_next = {2'b00, refl_count_reg[13:8]};
        macst_pkg::TX_START_ADDR: rd_next = {tx_busy, tx_start_shadow_reg[6:0]};
        default: rd_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_en ? rd_next : 8'h00;
    end
  end

  // ==========================================
  // Checks
  a_done_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_busy && tx_frame_ok && tx_last_packet |=> tx_flags[macst_pkg::TXS_DONE] && !tx_busy)
    else $error("done flag not set at bank end");
  a_w1c_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_tx_status && wr_data[macst_pkg::TXS_COLL] && !tx_set[macst_pkg::TXS_COLL]
    |=> !tx_flags[macst_pkg::TXS_COLL])
    else $error("collision flag survived a one write");
  a_zero_write_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_rx_status && !wr_data[macst_pkg::RXS_PKT] && rx_flags[macst_pkg::RXS_PKT]
    |=> rx_flags[macst_pkg::RXS_PKT])
    else $error("zero write cleared packet flag");
  a_irq_gating: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (tx_flags & tx_irq_enable_reg & 8'h79) == 8'h00 && (rx_flags & rx_irq_enable_reg) == 8'h00
    && !(tx_flags[7] && tx_irq_enable_reg[7]) && !(tx_flags[2] && tx_irq_enable_reg[2])
    && !(tx_flags[1] && tx_irq_enable_reg[1]) |-> !irq)
    else $error("interrupt without enabled flag");
  a_clear_drops_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_tx_status && wr_data == 8'h86 && !(|tx_set) && rx_irq_enable_reg == 8'h00 |=> !irq)
    else $error("interrupt held after clearing");
  a_excess_after16: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_collision && frame_active_reg && coll_count_reg == 4'hf
    |=> tx_flags[macst_pkg::TXS_EXCESS] && coll_count_reg == 4'h0)
    else $error("excess flag missing on sixteenth attempt");
  a_start_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_frame_start && !rx_accept |=> !tx_flags[macst_pkg::TXS_SELF_RX])
    else $error("self reception flag not cleared at start");
  a_discard_errored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_frame_end && rx_crc_err && receive_mode_reg == 8'h00 |-> rx_discard && !rx_store)
    else $error("errored packet kept with accepts off");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rd_en) && $past(addr) == macst_pkg::TX_STATUS_ADDR |-> rd_data[3] == 1'b0 && rd_data[0] == 1'b0)
    else $error("reserved status bit read as one");
  a_reset_clear: assert property (@(posedge ref_clk)
    !rst_n |=> tx_flags == 8'h00 && rx_flags == 8'h00)
    else $error("flags not zero after reset");
endmodule

//--- mac_status_regs_tb.sv
// Self-checking bench for the status and interrupt register bank.
// Assumes the far-end model and a short self-reception window.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module mac_status_regs_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic cs, fs, fok, col, last;
  logic [7:0] hlo = 8'h00;
  logic [7:0] hhi = 8'h00;
  logic hld = 1'b0;
  logic rx_end = 1'b0;
  logic crc = 1'b0;
  logic [10:0] len = 11'h000;
  logic [15:0] ty = 16'h0000;
  // Side inputs: tick, align error, buffer full, bus read error, end of DMA
  logic [4:0] aux = 5'h00;
  logic go, retry, skip, busy, store, discard, irq;
  logic [6:0] pcnt;
  logic [10:0] flen;
  logic [7:0] hst, hres, hll, hlh, v;
  logic [47:0] sta;
  logic [63:0] mct;
  logic st, ds;
  int failures = 0;
  int cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  int n_go = 0;
  int n_retry = 0;
  int n_skip = 0;
  // Pulse outputs counted mid-cycle, where they have settled
  always @(negedge ref_clk) begin
    n_go += go;
    n_retry += retry;
    n_skip += skip;
  end
  mac_far_model far (.ref_clk(ref_clk), .carrier_sense_pin(cs), .tx_frame_start(fs), .tx_frame_ok(fok),
    .tx_collision(col), .tx_last_packet(last));
  // Short window keeps the self-reception case quick
  mac_status_regs #(.SELF_RX_CYCLES(8)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .carrier_sense_pin(cs), .tx_frame_start(fs),
    .tx_frame_ok(fok), .tx_collision(col), .tx_last_packet(last), .refl_tick(aux[0]), .tx_hdr_lo(hlo),
    .tx_hdr_hi(hhi), .tx_hdr_load(hld), .rx_frame_end(rx_end), .rx_crc_err(crc), .rx_align_err(aux[1]),
    .rx_length(len), .rx_type(ty), .rx_buffer_full(aux[2]), .bus_read_err(aux[3]), .dma_end(aux[4]), .tx_go(go),
    .tx_packet_count(pcnt), .tx_retry(retry), .tx_skip(skip), .tx_busy(busy), .tx_frame_length(flen),
    .rx_store(store), .rx_discard(discard), .rx_hdr_status(hst), .rx_hdr_reserved(hres), .rx_hdr_len_lo(hll),
    .rx_hdr_len_hi(hlh), .station_address(sta), .multicast_table(mct), .irq(irq));
  // ==========================================
  // Bus and event tasks
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 `CHK("rd_data", e, rd_data)
  endtask
  task automatic packet_received_flag(input logic [10:0] l, input logic [15:0] t, input logic c);
    @(posedge ref_clk);
    rx_end <= 1'b1;
    len <= l;
    ty <= t;
    crc <= c;
    #1 st = store;
    ds = discard;
    @(posedge ref_clk);
    rx_end <= 1'b0;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_rd(macst_pkg::TX_STATUS_ADDR, 8'h00);
    chk_rd(macst_pkg::RX_STATUS_ADDR, 8'h00);
    wr(macst_pkg::TX_IRQ_EN_ADDR, 8'hff);
    chk_rd(macst_pkg::TX_IRQ_EN_ADDR, 8'h86);
    chk_rd(5'h1f, 8'h00);
    $display("test reset done");
    far.carrier(1'b1);
    repeat (6) @(posedge ref_clk);
    chk_rd(macst_pkg::TX_STATUS_ADDR, 8'h40);
    wr(macst_pkg::TX_START_ADDR, 8'h81);
    far.ev(0);
    far.carrier(1'b0);
    aux <= 5'h01;
    repeat (6) @(posedge ref_clk);
    aux <= 5'h00;
    far.ev(1);
    packet_received_flag(11'h040, 16'h0900, 1'b0);
    `CHK("rx_store", 1'b1, st)
    chk_rd(macst_pkg::TX_STATUS_ADDR, 8'hb0);
    `CHK("irq", 1'b1, irq)
    wr(macst_pkg::TX_STATUS_ADDR, 8'h00);
    chk_rd(macst_pkg::TX_STATUS_ADDR, 8'hb0);
    chk_rd(macst_pkg::REFL_LOW_ADDR, 8'h06);
    chk_rd(macst_pkg::REFL_HIGH_ADDR, 8'h00);
    // Clear done before restarting the transmitter
    wr(macst_pkg::TX_STATUS_ADDR, 8'h80);
    #1 `CHK("irq", 1'b0, irq)
    $display("test tx done");
    wr(macst_pkg::TX_START_ADDR, 8'h81);
    #1 `CHK("busy_cnt", 8'h81, {busy, pcnt})
    far.ev(0);
    far.ev(2);
    chk_rd(macst_pkg::TX_STATUS_ADDR, 8'h04);
    chk_rd(macst_pkg::TX_MODE_ADDR, 8'h10);
    for (int i = 0; i < 15; i++) begin
      far.ev(0);
      far.ev(2);
    end
    chk_rd(macst_pkg::TX_STATUS_ADDR, 8'h86);
    `CHK("busy", 1'b0, busy)
    `CHK("go_retry_skip", 24'h020f01, {8'(n_go), 8'(n_retry), 8'(n_skip)})
    `CHK("irq", 1'b1, irq)
    wr(macst_pkg::TX_STATUS_ADDR, 8'h86);
    #1 `CHK("irq", 1'b0, irq)
    $display("test collisions done");
    chk_rd(macst_pkg::RX_STATUS_ADDR, 8'h90);
    `CHK("hdr_status", 8'h30, hst)
    `CHK("hdr_len", 24'h400000, {hll, hlh, hres})
    wr(macst_pkg::RX_IRQ_EN_ADDR, 8'h10);
    #1 `CHK("irq", 1'b1, irq)
    wr(macst_pkg::RX_STATUS_ADDR, 8'h10);
    #1 `CHK("irq", 1'b0, irq)
    wr(macst_pkg::RX_STATUS_ADDR, 8'h80);
    chk_rd(macst_pkg::RX_STATUS_ADDR, 8'h00);
    packet_received_flag(11'h040, 16'h0800, 1'b1);
    `CHK("discard", 2'b01, {st, ds})
    wr(macst_pkg::RX_MODE_ADDR, 8'h08);
    packet_received_flag(11'h014, 16'h0800, 1'b0);
    `CHK("runt_store", 2'b10, {st, ds})
    chk_rd(macst_pkg::RX_STATUS_ADDR, 8'h88);
    `CHK("hdr_runt", 16'h0814, {hst, hll})
    aux <= 5'h04;
    packet_received_flag(11'h040, 16'h0800, 1'b0);
    `CHK("overflow", 2'b01, {st, ds})
    aux <= 5'h02;
    packet_received_flag(11'h040, 16'h0800, 1'b0);
    aux <= 5'h18;
    @(posedge ref_clk);
    aux <= 5'h00;
    chk_rd(macst_pkg::RX_STATUS_ADDR, 8'hed);
    `CHK("hdr_align", 8'h05, hst)
    wr(macst_pkg::RX_IRQ_EN_ADDR, 8'h40);
    #1 `CHK("irq", 1'b1, irq)
    wr(macst_pkg::RX_STATUS_ADDR, 8'hed);
    #1 `CHK("irq", 1'b0, irq)
    chk_rd(macst_pkg::RX_STATUS_ADDR, 8'h00);
    $display("test receive done");
    for (int i = 0; i < 8; i++) begin
      if (i < 6) begin
        wr(macst_pkg::NODE_ADDR_BASE + 5'(i), 8'ha0 + 8'(i));
      end
      wr(macst_pkg::HASH_BASE + 5'(i), 8'hc0 + 8'(i));
    end
    #1 `CHK("station", 48'ha5a4a3a2a1a0, sta)
    `CHK("filter", 64'hc7c6c5c4c3c2c1c0, mct)
    @(posedge ref_clk);
    hlo <= 8'h40;
    hhi <= 8'hfd;
    hld <= 1'b1;
    @(posedge ref_clk);
    hld <= 1'b0;
    #1 `CHK("frame_len", 11'h540, flen)
    $display("test tables done");
    final_report();
  end
  // Whole run needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    final_report();
  end
endmodule

//--- macst_pkg.sv
// Constants shared by the status and interrupt register bank.
// Assumes a single 200 MHz clock and byte-wide registers.
package macst_pkg;
  // ==========================================
  // Register map
  localparam int ADDR_W = 5;
  localparam logic [4:0] TX_STATUS_ADDR = 5'h00;
  localparam logic [4:0] RX_STATUS_ADDR = 5'h01;
  localparam logic [4:0] TX_IRQ_EN_ADDR = 5'h02;
  localparam logic [4:0] RX_IRQ_EN_ADDR = 5'h03;
  localparam logic [4:0] TX_MODE_ADDR = 5'h04;
  localparam logic [4:0] RX_MODE_ADDR = 5'h05;
  localparam logic [4:0] NODE_ADDR_BASE = 5'h08;
  localparam logic [4:0] REFL_LOW_ADDR = 5'h0e;
  localparam logic [4:0] REFL_HIGH_ADDR = 5'h0f;
  localparam logic [4:0] HASH_BASE = 5'h10;
  localparam logic [4:0] TX_START_ADDR = 5'h18;
  localparam int NODE_BYTES = 6;
  localparam int HASH_BYTES = 8;
  // ==========================================
  // Field positions
  localparam int TXS_DONE = 7;
  localparam int TXS_CARRIER = 6;
  localparam int TXS_SELF_RX = 5;
  localparam int TXS_CARRIER_LOST_FLAG = 4;
  localparam int TXS_COLL = 2;
  localparam int TXS_EXCESS = 1;
  localparam logic [7:0] TX_IRQ_MASK = 8'h86;
  localparam int RXS_PKT = 7;
  localparam int RXS_BUS_RD = 6;
  localparam int RXS_DMA_EOP = 5;
  localparam int RXS_REMOTE = 4;
  localparam int RXS_SHORT = 3;
  localparam int RXS_ALIGN = 2;
  localparam int RXS_CRC = 1;
  localparam int RXS_OVF = 0;
  localparam int RXM_ACCEPT_ERR = 5;
  localparam int RXM_ACCEPT_RUNT = 3;
  localparam int HDR_GOOD = 5;
  localparam int TXM_COUNT_LSB = 4;
  localparam int TX_GO_BIT = 7;
  // ==========================================
  // Values and timing
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] REMOTE_TYPE = 16'h0900;
  localparam int LEN_W = 11;
  localparam logic [10:0] MIN_FRAME_LEN = 11'h03c;
  localparam logic [3:0] MAX_RETRY = 4'hf;
  localparam int REFL_W = 14;
  localparam int CLK_MHZ = 200;
  localparam int SELF_RX_WINDOW_NS = 9600;
  localparam int SELF_RX_CYCLES = SELF_RX_WINDOW_NS * CLK_MHZ / 1000;
  localparam int WIN_W = 12;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;
endpackage

//--- pin_sync.sv
// Three-stage synchroniser for a pin level.
// The output moves only once stages two and three agree.
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pin and result
  input wire logic pin,
  output logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level <= s3_reg;
      end
    end
  end
endmodule

//--- status_flag.sv
// One sticky status flag, set by device logic, cleared by a pulse.
// Assumes set and clear are same-clock single-cycle pulses.
`timescale 1ns/1ps
module status_flag (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Events
  input wire logic set,
  input wire logic clear,
  // State
  output logic flag
);
  // A set in the clearing cycle wins so no event is lost
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule
